// file: design/dsod_top.sv
// status-output detection: flags, comparators, timers, terminal routing
// assumes measurements synchronous to clk and an axi4-lite master
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - fault flag follows drive trip
// - fault on relay by default; codes 99/199
// - hardware-fault flag for listed internal faults
// - codes 91/191 route hardware-fault flag
// - accel overcurrent with earth fault sets it
// - running flag on run terminal by default
// - arrival flag inside band of set frequency
// - codes 1/101 route arrival flag
// - threshold flag at or above forward threshold
// - reverse threshold in reverse; 9999 means forward
// - threshold terminal default; codes 4/104
// - dc braking forces frequency flags off
// - compare frequency taken before slip compensation
// - overcurrent flag after level exceeded past delay
// - overcurrent delay zero to ten seconds
// - overcurrent flag held about 100 ms
// - codes 12/112 route overcurrent flag
// - zero-current flag after low current past time
// - zero-current flag held about 100 ms
// - codes 13/113 route zero-current flag
// - zero-current level zero disables detection
// - current detectors also run during auto tuning
// - codes below 100 conduct, 100 to 199 invert
// - running when at or above starting frequency, not braking
module dsod_top #(
    parameter int TICK_CYC = dsod_pkg::TICK_CYC,
    parameter int HOLD_TICKS = dsod_pkg::HOLD_TICKS,
    parameter int NTERM = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // drive measurements
    input wire dsod_pkg::dsod_meas_t meas,
    // terminals and flags
    output logic [NTERM-1:0] term_out,
    output dsod_pkg::dsod_flags_t flags,
    // axi4-lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    localparam int TW = $clog2(TICK_CYC + 1);
    localparam logic [15:0] HOLD_N = 16'(HOLD_TICKS);

    // refuse settings the counters cannot serve
    if (TICK_CYC < 1 || HOLD_TICKS < 1 || HOLD_TICKS > 65535 ||
        NTERM != 3) begin : g_chk
        $error("dsod_top: bad parameter");
    end

    // decoded index of a register byte address, NCFG when unmapped
    function automatic int reg_idx(input logic [7:0] a);
        if (a[1:0] != 2'h0 || a > dsod_pkg::A_START_F) begin
            return dsod_pkg::NCFG;
        end
        return int'(a[7:2]);
    endfunction

    // saturating tick counter step, restarts when the condition drops
    function automatic logic [15:0] tstep(input logic c, input logic t,
                                          input logic [15:0] n);
        if (!c) begin
            return 16'h0000;
        end
        // saturate, never wrap
        if (t && n != 16'hFFFF) begin
            return n + 16'h0001;
        end
        return n;
    endfunction

    // flag picked by a terminal's assignment code
    function automatic logic route(input logic [15:0] code,
                                   input dsod_pkg::dsod_flags_t f);
        logic [7:0] base;
        logic inv;
        logic v;
        base = 8'h00;
        inv = 1'b0;
        v = 1'b0;
        if (code[15:8] == 8'h00 && code[7:0] <= dsod_pkg::NEG_MAX) begin
            // 100 up: inverted twin
            inv = code[7:0] >= dsod_pkg::NEG_OFS;
            base = inv ? code[7:0] - dsod_pkg::NEG_OFS : code[7:0];
            case (base)
                dsod_pkg::C_RUN: v = f.run_flag;
                dsod_pkg::C_ARRIVE: v = f.freq_arrival_flag;
                dsod_pkg::C_THRESH: v = f.freq_threshold_flag;
                dsod_pkg::C_OVERCUR: v = f.overcurrent_flag;
                dsod_pkg::C_ZEROCUR: v = f.zero_current_flag;
                dsod_pkg::C_HWFAULT: v = f.hw_fault_flag;
                dsod_pkg::C_FAULT: v = f.fault_flag;
                default: begin
                    v = 1'b0;
                    inv = 1'b0; // no function: terminal stays open
                end
            endcase
        end
        return v ^ inv;
    endfunction

    // settings by register index
    logic [15:0] cfg_r [dsod_pkg::NCFG];

    // tick and current timers
    logic [TW-1:0] pre_r;
    logic tick_r;
    logic [15:0] oc_cnt_r;
    logic [15:0] zc_cnt_r;
    logic [15:0] oc_hold_r;
    logic [15:0] zc_hold_r;

    // comparator terms
    logic [15:0] thr;
    logic [31:0] diff_x100;
    logic [31:0] band_x;

    // detector terms, next flags
    logic run_c;
    logic det_run;
    logic oc_cond;
    logic zc_cond;
    logic oc_q;
    logic zc_q;
    logic hw_c;
    dsod_pkg::dsod_flags_t fl;

    // bus decode
    int widx;
    int ridx;
    logic [15:0] rd_v;

    // 10 ms time base shared by all timers
    // tick_r high one cycle per period
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_r <= '0;
            tick_r <= 1'b0;
        end else if (pre_r == TW'(TICK_CYC - 1)) begin
            pre_r <= '0;
            tick_r <= 1'b1;
        end else begin
            pre_r <= pre_r + TW'(1);
            tick_r <= 1'b0;
        end
    end

    // running indication and frequency comparisons on pre-slip value
    always_comb begin
        run_c = meas.start_on && !meas.dc_brake &&
                meas.out_freq >= cfg_r[10];
        // reverse uses its own threshold unless marked same
        thr = (meas.reverse && cfg_r[2] != dsod_pkg::SAME_AS_FWD) ?
              cfg_r[2] : cfg_r[1];
        // |f - fset| * 100 <= fset * band, no division needed
        diff_x100 = (meas.out_freq >= meas.set_freq) ?
            32'(meas.out_freq - meas.set_freq) * 32'd100 :
            32'(meas.set_freq - meas.out_freq) * 32'd100;
        band_x = 32'(meas.set_freq) * 32'(cfg_r[0]);
    end

    // current detector conditions; tuning keeps them alive
    always_comb begin
        det_run = run_c || meas.autotune;
        oc_cond = det_run && meas.out_current > cfg_r[3];
        zc_cond = det_run && cfg_r[5] != 16'h0000 &&
                  meas.out_current < cfg_r[5];
        // strictly longer than the set delay
        oc_q = oc_cond && oc_cnt_r > cfg_r[4];
        zc_q = zc_cond && zc_cnt_r > cfg_r[6];
    end

    // qualifying timers restart whenever the condition drops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oc_cnt_r <= 16'h0000;
        end else begin
            oc_cnt_r <= tstep(oc_cond, tick_r, oc_cnt_r);
        end
    end

    // zero-current timer, same restart
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            zc_cnt_r <= 16'h0000;
        end else begin
            zc_cnt_r <= tstep(zc_cond, tick_r, zc_cnt_r);
        end
    end

    // minimum on time once a current flag rises
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oc_hold_r <= 16'h0000;
        end else if (oc_q) begin
            oc_hold_r <= HOLD_N;
        end else if (tick_r && oc_hold_r != 16'h0000) begin
            oc_hold_r <= oc_hold_r - 16'h0001;
        end
    end

    // zero-current hold, same scheme
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            zc_hold_r <= 16'h0000;
        end else if (zc_q) begin
            zc_hold_r <= HOLD_N;
        end else if (tick_r && zc_hold_r != 16'h0000) begin
            zc_hold_r <= zc_hold_r - 16'h0001;
        end
    end

    // hardware-fault decode of the active trip code
    always_comb begin
        case (meas.fault_code)
            dsod_pkg::F_BRAKE_TR,
            dsod_pkg::F_EARTH,
            dsod_pkg::F_PHASE_LOSS,
            dsod_pkg::F_PARAM_STORE,
            dsod_pkg::F_BOARD,
            dsod_pkg::F_CPU,
            dsod_pkg::F_INRUSH: hw_c = meas.tripped;
            // earth fault may surface as an accel overcurrent
            dsod_pkg::F_ACCEL_OC: hw_c = meas.tripped && meas.earth_fault;
            // any other code leaves it off
            default: hw_c = 1'b0;
        endcase
    end

    // flag vector before registering
    always_comb begin
        fl.run_flag = run_c;
        fl.freq_arrival_flag = !meas.dc_brake &&
                               diff_x100 <= band_x;
        fl.freq_threshold_flag = !meas.dc_brake &&
                                 meas.out_freq >= thr;
        fl.overcurrent_flag = oc_q || oc_hold_r != 16'h0000;
        fl.zero_current_flag = zc_q || zc_hold_r != 16'h0000;
        fl.hw_fault_flag = hw_c;
        fl.fault_flag = meas.tripped;
    end

    // flags and terminals straight from flip-flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags <= '0;
            term_out <= '0;
        end else begin
            // terminals see the same flags
            flags <= fl;
            for (int i = 0; i < NTERM; i++) begin
                term_out[i] <= route(cfg_r[7 + i], fl);
            end
        end
    end

    // register index decode and read-data mux
    always_comb begin
        widx = reg_idx(awaddr);
        ridx = reg_idx(araddr);
        rd_v = 16'h0000;
        if (araddr == dsod_pkg::A_STATUS) begin
            rd_v = 16'(fl);
        end else if (ridx < dsod_pkg::NCFG) begin
            rd_v = cfg_r[ridx];
        end
    end

    // configuration store; only low two byte lanes are meaningful
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_r[0] <= dsod_pkg::RV_BAND;
            cfg_r[1] <= dsod_pkg::RV_FWD_THR;
            cfg_r[2] <= dsod_pkg::RV_REV_THR;
            cfg_r[3] <= dsod_pkg::RV_OC_LVL;
            cfg_r[4] <= dsod_pkg::RV_OC_DLY;
            cfg_r[5] <= dsod_pkg::RV_ZC_LVL;
            cfg_r[6] <= dsod_pkg::RV_ZC_TIME;
            cfg_r[7] <= dsod_pkg::RV_ASSIGN0;
            cfg_r[8] <= dsod_pkg::RV_ASSIGN1;
            cfg_r[9] <= dsod_pkg::RV_ASSIGN2;
            cfg_r[10] <= dsod_pkg::RV_START_F;
        end else if (awvalid && wvalid && !bvalid &&
                     widx < dsod_pkg::NCFG) begin
            // upper lanes have no storage
            if (wstrb[0]) begin
                cfg_r[widx][7:0] <= wdata[7:0];
            end
            if (wstrb[1]) begin
                cfg_r[widx][15:8] <= wdata[15:8];
            end
        end
    end

    // write handshake and response
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= dsod_pkg::RESP_OKAY;
        end else if (bvalid) begin
            // a waiting response blocks writes
            awready <= 1'b0;
            wready <= 1'b0;
            if (bready) begin
                bvalid <= 1'b0;
            end
        end else if (awvalid && wvalid && !awready) begin
            // ready pulses one cycle; store happens the same edge
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b1;
            bresp <= (widx < dsod_pkg::NCFG) ? dsod_pkg::RESP_OKAY :
                     dsod_pkg::RESP_SLVERR;
        end else begin
            awready <= 1'b0;
            wready <= 1'b0;
        end
    end

    // read handshake; status word is read-only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= dsod_pkg::RESP_OKAY;
        end else if (rvalid) begin
            // rdata frozen until rready
            arready <= 1'b0;
            if (rready) begin
                rvalid <= 1'b0;
            end
        end else if (arvalid && !arready) begin
            arready <= 1'b1;
            rvalid <= 1'b1;
            rdata <= {16'h0000, rd_v};
            rresp <= (ridx < dsod_pkg::NCFG ||
                      araddr == dsod_pkg::A_STATUS) ?
                     dsod_pkg::RESP_OKAY : dsod_pkg::RESP_SLVERR;
        end else begin
            arready <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// file: shared/dsod_pkg.sv
// constants, register map and carrier types for the drive status detector
// assumes a 10 MHz control clock and a 32-bit axi4-lite register bus
package dsod_pkg;
    // clock and time base
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int HOLD_MS = 100;
    localparam int HOLD_TICKS = HOLD_MS / TICK_MS;

    // register byte offsets
    localparam logic [7:0] A_BAND = 8'h00;
    localparam logic [7:0] A_FWD_THR = 8'h04;
    localparam logic [7:0] A_REV_THR = 8'h08;
    localparam logic [7:0] A_OC_LVL = 8'h0C;
    localparam logic [7:0] A_OC_DLY = 8'h10;
    localparam logic [7:0] A_ZC_LVL = 8'h14;
    localparam logic [7:0] A_ZC_TIME = 8'h18;
    localparam logic [7:0] A_ASSIGN0 = 8'h1C;
    localparam logic [7:0] A_ASSIGN1 = 8'h20;
    localparam logic [7:0] A_ASSIGN2 = 8'h24;
    localparam logic [7:0] A_START_F = 8'h28;
    localparam logic [7:0] A_STATUS = 8'h2C;
    localparam int NCFG = 11;

    // reset values; frequency in 0.1 Hz, current in %, times in ticks
    localparam logic [15:0] RV_BAND = 16'h000A;
    localparam logic [15:0] RV_FWD_THR = 16'h003C;
    localparam logic [15:0] RV_REV_THR = 16'h270F;
    localparam logic [15:0] RV_OC_LVL = 16'h0096;
    localparam logic [15:0] RV_OC_DLY = 16'h0000;
    localparam logic [15:0] RV_ZC_LVL = 16'h0005;
    localparam logic [15:0] RV_ZC_TIME = 16'h0032;
    localparam logic [15:0] RV_ASSIGN0 = 16'h0000;
    localparam logic [15:0] RV_ASSIGN1 = 16'h0004;
    localparam logic [15:0] RV_ASSIGN2 = 16'h0063;
    localparam logic [15:0] RV_START_F = 16'h0005;
    localparam logic [15:0] SAME_AS_FWD = 16'h270F;

    // assignment codes, inverted logic adds NEG_OFS
    localparam logic [7:0] C_RUN = 8'h00;
    localparam logic [7:0] C_ARRIVE = 8'h01;
    localparam logic [7:0] C_THRESH = 8'h04;
    localparam logic [7:0] C_OVERCUR = 8'h0C;
    localparam logic [7:0] C_ZEROCUR = 8'h0D;
    localparam logic [7:0] C_HWFAULT = 8'h5B;
    localparam logic [7:0] C_FAULT = 8'h63;
    localparam logic [7:0] NEG_OFS = 8'h64;
    localparam logic [7:0] NEG_MAX = 8'hC7;

    // fault codes; values are arbitrary
    localparam logic [7:0] F_BRAKE_TR = 8'h10;
    localparam logic [7:0] F_EARTH = 8'h11;
    localparam logic [7:0] F_PHASE_LOSS = 8'h12;
    localparam logic [7:0] F_PARAM_STORE = 8'h13;
    localparam logic [7:0] F_BOARD = 8'h14;
    localparam logic [7:0] F_CPU = 8'h15;
    localparam logic [7:0] F_INRUSH = 8'h16;
    localparam logic [7:0] F_ACCEL_OC = 8'h17;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // measured drive state
    typedef struct packed {
        logic [15:0] out_freq;
        logic [15:0] set_freq;
        logic [15:0] out_current;
        logic reverse;
        logic start_on;
        logic dc_brake;
        logic autotune;
        logic tripped;
        logic earth_fault;
        logic [7:0] fault_code;
    } dsod_meas_t;

    // internal status flags
    typedef struct packed {
        logic run_flag;
        logic freq_arrival_flag;
        logic freq_threshold_flag;
        logic overcurrent_flag;
        logic zero_current_flag;
        logic hw_fault_flag;
        logic fault_flag;
    } dsod_flags_t;
endpackage

// file: test/dsod_asserts.sv
// checker on the detector ports, bound into dsod_top
// assumes one clock and the short test tick of 4 cycles
`timescale 1ns/1ps
`default_nettype none
module dsod_asserts #(
    parameter int TICK_CYC = 4,
    parameter int HOLD_TICKS = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // status side
    input wire dsod_pkg::dsod_meas_t meas,
    input wire dsod_pkg::dsod_flags_t flags,
    // register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // request seen by an idle slave, then its answer
    sequence s_wr_req;
        awvalid && wvalid && !bvalid && !awready;
    endsequence
    sequence s_wr_ans;
        awready && wready && bvalid;
    endsequence
    sequence s_rd_req;
        arvalid && !rvalid && !arready;
    endsequence

    // past(rst_b) skips the edge where flags still show reset
    chk_fault_follows: assert property (
        $past(rst_b) |-> flags.fault_flag == $past(meas.tripped))
        else $error("fault flag does not follow trip");
    chk_hw_earth_oc: assert property (
        $past(rst_b) && $past(meas.tripped) && $past(meas.earth_fault)
        && $past(meas.fault_code) == dsod_pkg::F_ACCEL_OC
        |-> flags.hw_fault_flag)
        else $error("hw fault flag missing on earth fault");
    chk_brake_clear: assert property (
        $past(rst_b) && $past(meas.dc_brake) |-> !flags.run_flag
        && !flags.freq_arrival_flag && !flags.freq_threshold_flag)
        else $error("flag on during dc braking");
    // 5 cycles checked; the shortest hold with two ticks of four is 6
    chk_oc_hold: assert property (
        $rose(flags.overcurrent_flag) |-> flags.overcurrent_flag [*5])
        else $error("overcurrent flag dropped early");
    chk_zc_hold: assert property (
        $rose(flags.zero_current_flag) |-> flags.zero_current_flag [*5])
        else $error("zero current flag dropped early");
    chk_oc_running: assert property (
        $rose(flags.overcurrent_flag)
        |-> $past(meas.start_on || meas.autotune))
        else $error("overcurrent flag while not running");
    chk_wr_answer: assert property (s_wr_req |=> s_wr_ans)
        else $error("write not answered in one cycle");
    chk_b_stands: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    chk_rd_answer: assert property (s_rd_req |=> arready && rvalid)
        else $error("read not answered in one cycle");
    chk_r_stands: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
endmodule

bind dsod_top dsod_asserts #(
    .TICK_CYC(TICK_CYC),
    .HOLD_TICKS(HOLD_TICKS)
) u_dsod_asserts (
    .clk(clk), .rst_b(rst_b), .meas(meas), .flags(flags),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .rready(rready), .rdata(rdata)
);
`default_nettype wire

// file: test/dsod_term_reader.sv
// far-side model: a controller reading the output terminals
// assumes terminal levels are registered by the detector on clk
`timescale 1ns/1ps
`default_nettype none
module dsod_term_reader (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // terminal levels from the detector
    input wire logic [2:0] term_out,
    // contacts as the controller sees them
    output logic [2:0] seen_r
);
    // a conducting terminal closes its input one clock later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seen_r <= 3'h0;
        end else begin
            seen_r <= term_out;
        end
    end
endmodule
`default_nettype wire

// file: test/test_drive_status_output_detect.sv
// self-checking bench for the drive status detector
// assumes short timer parameters: 4 cycles a tick, hold of 2 ticks
`timescale 1ns/1ps
`default_nettype none
module test_drive_status_output_detect;
    typedef struct packed {
        logic [15:0] fr;
        logic [15:0] st;
        logic [5:0] b;
        logic [7:0] cd;
        logic [6:0] ex;
    } dsod_row_t;
    // b holds reverse, start, brake, tune, trip, earth
    dsod_row_t rows [17] = '{
        '{16'h0258, 16'h0258, 6'h10, 8'h00, 7'h70},
        '{16'h021C, 16'h0258, 6'h10, 8'h00, 7'h70},
        '{16'h021B, 16'h0258, 6'h10, 8'h00, 7'h50},
        '{16'h003B, 16'h003B, 6'h10, 8'h00, 7'h60},
        '{16'h003C, 16'h003C, 6'h10, 8'h00, 7'h70},
        '{16'h003C, 16'h003C, 6'h30, 8'h00, 7'h70},
        '{16'h003B, 16'h003B, 6'h30, 8'h00, 7'h60},
        '{16'h0258, 16'h0258, 6'h18, 8'h00, 7'h00},
        '{16'h0258, 16'h0258, 6'h1A, dsod_pkg::F_BRAKE_TR, 7'h03},
        '{16'h0258, 16'h0258, 6'h1A, dsod_pkg::F_EARTH, 7'h03},
        '{16'h0258, 16'h0258, 6'h1A, dsod_pkg::F_PHASE_LOSS, 7'h03},
        '{16'h0258, 16'h0258, 6'h1A, dsod_pkg::F_PARAM_STORE, 7'h03},
        '{16'h0258, 16'h0258, 6'h1A, dsod_pkg::F_BOARD, 7'h03},
        '{16'h0258, 16'h0258, 6'h1A, dsod_pkg::F_CPU, 7'h03},
        '{16'h0258, 16'h0258, 6'h1A, dsod_pkg::F_INRUSH, 7'h03},
        '{16'h0258, 16'h0258, 6'h1B, dsod_pkg::F_ACCEL_OC, 7'h03},
        '{16'h0258, 16'h0258, 6'h1A, dsod_pkg::F_ACCEL_OC, 7'h01}};
    logic [7:0] codes [7] = '{dsod_pkg::C_RUN, dsod_pkg::C_ARRIVE,
        dsod_pkg::C_THRESH, dsod_pkg::C_OVERCUR, dsod_pkg::C_ZEROCUR,
        dsod_pkg::C_HWFAULT, dsod_pkg::C_FAULT};
    logic [15:0] rv [11] = '{dsod_pkg::RV_BAND, dsod_pkg::RV_FWD_THR,
        dsod_pkg::RV_REV_THR, dsod_pkg::RV_OC_LVL, dsod_pkg::RV_OC_DLY,
        dsod_pkg::RV_ZC_LVL, dsod_pkg::RV_ZC_TIME, dsod_pkg::RV_ASSIGN0,
        dsod_pkg::RV_ASSIGN1, dsod_pkg::RV_ASSIGN2, dsod_pkg::RV_START_F};
    localparam logic [6:0] EXP = 7'h73;
    // ports and bench state
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    dsod_pkg::dsod_meas_t meas = '0;
    dsod_pkg::dsod_flags_t flags;
    logic [2:0] term_out, seen_r;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, c;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    int errors = 0, comparisons = 0;

    dsod_top #(.TICK_CYC(4), .HOLD_TICKS(2), .NTERM(3)) u_dsod_top (
        .clk(clk), .rst_b(rst_b), .meas(meas), .term_out(term_out),
        .flags(flags), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    dsod_term_reader u_dsod_term_reader (.clk(clk), .rst_b(rst_b),
        .term_out(term_out), .seen_r(seen_r));

    always #50 clk = ~clk;

    function automatic dsod_pkg::dsod_meas_t mk(logic [15:0] f,
        logic [15:0] s, logic [15:0] cur, logic [5:0] b, logic [7:0] cd);
        return '{f, s, cur, b[5], b[4], b[3], b[2], b[1], b[0], cd};
    endfunction

    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // write: address and data offered together, held until answered
    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
        end while (bvalid !== 1'b1);
        resp = bresp;
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b0;
    endtask

    task automatic rd_reg(logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
        end while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        arvalid <= 1'b0;
        rready <= 1'b0;
    endtask

    // bounded wait on one flag bit
    task automatic wait_flag(int b, logic v, int lim);
        int n;
        n = 0;
        while (flags[b] !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        check("flag wait", {31'h0, v}, {31'h0, flags[b]});
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #500_000;
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        // table rows at default settings, current mid-range
        foreach (rows[i]) begin
            @(posedge clk);
            meas <= mk(rows[i].fr, rows[i].st, 16'h0032, rows[i].b,
                rows[i].cd);
            repeat (2) @(posedge clk);
            check("flags", {25'h0, rows[i].ex}, {25'h0, flags});
            check("terms", {29'h0, rows[i].ex[0], rows[i].ex[4],
                rows[i].ex[6]}, {29'h0, term_out});
        end
        // every code on the run terminal, in both senses
        @(posedge clk);
        meas <= mk(16'h0258, 16'h0258, 16'h0032, 6'h12, dsod_pkg::F_BOARD);
        foreach (codes[i]) begin
            for (int n = 0; n < 2; n++) begin
                c = n[0] ? codes[i] + dsod_pkg::NEG_OFS : codes[i];
                wr(dsod_pkg::A_ASSIGN0, {8'h00, c});
                repeat (2) @(posedge clk);
                check("term0", {31'h0, EXP[6 - i] ^ n[0]},
                    {31'h0, term_out[0]});
            end
        end
        wr(dsod_pkg::A_ASSIGN0, 16'h0002);
        repeat (2) @(posedge clk);
        check("no func", 32'h0, {31'h0, term_out[0]});
        check("far side", {29'h0, term_out}, {29'h0, seen_r});
        // reverse threshold of 10 Hz against 8 Hz
        wr(dsod_pkg::A_REV_THR, 16'h0064);
        for (int n = 0; n < 2; n++) begin
            @(posedge clk);
            meas <= mk(16'h0050, 16'h0050, 16'h0032, {n[0], 5'h10}, 8'h00);
            repeat (2) @(posedge clk);
            check("rev thr", {31'h0, ~n[0]},
                {31'h0, flags.freq_threshold_flag});
        end
        // broken overcurrent runs must not add up
        wr(dsod_pkg::A_OC_DLY, 16'h0003);
        for (int n = 0; n < 2; n++) begin
            @(posedge clk);
            meas <= mk(16'h0258, 16'h0258, 16'h00A0, 6'h10, 8'h00);
            repeat (10) @(posedge clk);
            meas.out_current <= 16'h0032;
            repeat (3) @(posedge clk);
        end
        check("oc restart", 32'h0, {31'h0, flags[3]});
        meas.out_current <= 16'h00A0;
        repeat (10) @(posedge clk);
        check("oc early", 32'h0, {31'h0, flags[3]});
        wait_flag(3, 1'b1, 30);
        meas.out_current <= 16'h0032;
        wait_flag(3, 1'b0, 40);
        meas <= mk(16'h0000, 16'h0000, 16'h00A0, 6'h04, 8'h00);
        wait_flag(3, 1'b1, 40);
        // zero level disables, default level detects
        wr(dsod_pkg::A_ZC_TIME, 16'h0002);
        wr(dsod_pkg::A_ZC_LVL, 16'h0000);
        meas <= mk(16'h0258, 16'h0258, 16'h0000, 6'h10, 8'h00);
        repeat (40) @(posedge clk);
        check("zc off", 32'h0, {31'h0, flags[2]});
        wr(dsod_pkg::A_ZC_LVL, 16'h0005);
        wait_flag(2, 1'b1, 40);
        // reset in mid-run restores every default
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        check("reset", 32'h0, {22'h0, flags, term_out});
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        check("run term", 32'h1, {31'h0, term_out[0]});
        foreach (rv[i]) begin
            rd_reg(8'(i * 4));
            check("reset value", {16'h0, rv[i]}, rd);
        end
        rd_reg(8'h30);
        check("unmapped", {30'h0, dsod_pkg::RESP_SLVERR}, {30'h0, resp});
        wr(dsod_pkg::A_STATUS, 16'h0000);
        check("status wr", {30'h0, dsod_pkg::RESP_SLVERR}, {30'h0, resp});
        report_and_stop();
    end
endmodule
`default_nettype wire
